// ### rtl/rsl_pkg.sv
// shared constants and types of the reset and strap latch block
// assumes one 50 mhz clock; pin inputs arrive unsynchronised
package rsl_pkg;

  // clock and timing figures in ns, with cycle counts derived from them
  localparam int CLK_PERIOD_NS    = 20;
  localparam int PARTIAL_MIN_NS   = 50;   // shortest low time taken as a reset
  localparam int FULL_MIN_NS      = 1200; // shortest low time taken as a full reset
  localparam int RESET_TO_CONV_NS = 300;  // least gap from release to conversion start
  localparam int CONV_TIME_NS     = 500;  // conversion time of the core
  // least times round up, longest times round down, never below one cycle
  localparam int PARTIAL_MIN_CYC   = (PARTIAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FULL_MIN_CYC      = (FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_TO_CONV_CYC = (RESET_TO_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC_RAW      = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int CONV_CYC          = (CONV_CYC_RAW < 1) ? 1 : CONV_CYC_RAW;
  localparam int CNT_W             = 7;    // wide enough for every count above

  // register byte addresses on the avalon slave
  localparam logic [4:0] ADDR_STATUS   = 5'h00;
  localparam logic [4:0] ADDR_CONFIG   = 5'h04;
  localparam logic [4:0] ADDR_RESULT_A = 5'h08;
  localparam logic [4:0] ADDR_RESULT_B = 5'h0c;
  localparam logic [4:0] ADDR_LSB      = 5'h10;

  // config register fields
  localparam int CFG_RANGE_LSB  = 0;  // 3 bits, range code in software mode
  localparam int CFG_BURST_BIT  = 3;  // burst sequencing
  localparam int CFG_LAST_LSB   = 4;  // 3 bits, last channel of the sequence
  localparam int CFG_SEQ_EN_BIT = 7;  // sequencer enable in software mode
  localparam logic [7:0] CFG_RESET = 8'h74;

  // status register fields
  localparam int ST_BANDGAP_BIT = 0;
  localparam int ST_SOFT_BIT    = 1;
  localparam int ST_SEQ_BIT     = 2;
  localparam int ST_IFACE_LSB   = 3;  // 2 bits
  localparam int ST_HWRNG_LSB   = 5;  // 2 bits
  localparam int ST_BUSY_BIT    = 7;
  localparam int ST_VALID_BIT   = 8;
  localparam int ST_FULL_BIT    = 9;  // last reset was full
  localparam int ST_EARLY_BIT   = 10; // sticky, write one to clear
  localparam int ST_CHAN_LSB    = 11; // 3 bits
  localparam int ST_BYTESER_BIT = 14;

  // input range codes and their lsb weights in microvolts
  localparam logic [2:0] RNG_2P5 = 3'h0;
  localparam logic [2:0] RNG_3   = 3'h1;
  localparam logic [2:0] RNG_5   = 3'h2;
  localparam logic [2:0] RNG_6   = 3'h3;
  localparam logic [2:0] RNG_10  = 3'h4;
  localparam logic [2:0] RNG_12  = 3'h5;
  localparam logic [8:0] LSB_UV_2P5 = 9'h04c; // 76
  localparam logic [8:0] LSB_UV_3   = 9'h05c; // 92
  localparam logic [8:0] LSB_UV_5   = 9'h098; // 152
  localparam logic [8:0] LSB_UV_6   = 9'h0b7; // 183
  localparam logic [8:0] LSB_UV_10  = 9'h131; // 305
  localparam logic [8:0] LSB_UV_12  = 9'h16e; // 366
  localparam logic [1:0] HW_SOFTWARE = 2'h0;   // strap value meaning software mode

  // strap pins captured together
  typedef struct packed {
    logic       byte_serial; // high byte, low serial
    logic       iface_sel;   // low parallel
    logic       seq;         // sequencer strap
    logic [1:0] hw_range;    // range and mode strap
    logic       ref_src;     // high internal band-gap
  } rsl_straps_t;
  localparam rsl_straps_t STRAPS_RESET = '0;

  typedef enum logic [1:0] {RSL_IF_PARALLEL, RSL_IF_SERIAL, RSL_IF_BYTE} rsl_iface_t;
  typedef enum logic {RSL_RS_RUN, RSL_RS_LOW} rsl_rst_state_t;

endpackage

// ### rtl/rsl_reset_strap.sv
// reset classification, strap latching, conversion control and result format
// assumes an avalon-mm master on sys_clk_in and a converter core giving
// offset-binary samples with one extra half-lsb bit on the same clock
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none

module rsl_reset_strap (
  input  wire logic        sys_clk_in,                // 50 mhz clock
  input  wire logic        rst_in,                    // synchronous power-on reset
  input  wire logic        reset_pin_n_in,            // device reset pin, active low
  input  wire logic        conversion_start_input_in, // conversion start pin
  input  wire logic        reference_source_strap_in, // reference strap pin
  input  wire logic        sequencer_strap_in,        // sequencer strap pin
  input  wire logic [1:0]  hardware_range_strap_in,   // range and mode straps
  input  wire logic        interface_select_strap_in, // interface strap pin
  input  wire logic        byte_serial_strap_in,      // byte or serial strap pin
  input  wire logic [16:0] core_sample_a_in,          // core sample a, offset binary
  input  wire logic [16:0] core_sample_b_in,          // core sample b, offset binary
  input  wire logic [4:0]  avs_address_in,            // byte address
  input  wire logic        avs_read_in,               // read request
  input  wire logic        avs_write_in,              // write request
  input  wire logic [31:0] avs_writedata_in,          // write data
  input  wire logic [3:0]  avs_byteenable_in,         // byte enables
  output logic      [31:0] avs_readdata_out,          // read data, registered
  output logic             avs_waitrequest_out,       // stall until answer
  output logic             bandgap_enable_out,        // internal band-gap on
  output logic             reference_io_pin_oe_out,   // band-gap drives reference pin
  output logic             ref_buffer_enable_out,     // reference buffer on
  output logic             software_mode_out,         // software mode latched
  output logic             data_pins_write_en_out,    // data pins also accept writes
  output logic      [1:0]  iface_mode_out,            // selected interface
  output logic      [2:0]  range_code_out,            // active input range
  output logic      [8:0]  lsb_uv_out,                // lsb weight in microvolts
  output logic             sequencer_enable_out,      // channel sequencer on
  output logic      [2:0]  channel_out,               // current channel pair
  output logic             conv_busy_out,             // conversion running
  output logic             result_valid_out,          // results hold valid data
  output logic             device_in_reset_out        // reset pin seen low
);

  // lsb weight of a range code
  function automatic logic [8:0] lsb_of(input logic [2:0] rng);
    unique case (rng)
      rsl_pkg::RNG_2P5: lsb_of = rsl_pkg::LSB_UV_2P5;
      rsl_pkg::RNG_3:   lsb_of = rsl_pkg::LSB_UV_3;
      rsl_pkg::RNG_5:   lsb_of = rsl_pkg::LSB_UV_5;
      rsl_pkg::RNG_6:   lsb_of = rsl_pkg::LSB_UV_6;
      rsl_pkg::RNG_10:  lsb_of = rsl_pkg::LSB_UV_10;
      rsl_pkg::RNG_12:  lsb_of = rsl_pkg::LSB_UV_12;
      default:          lsb_of = rsl_pkg::LSB_UV_10; // codes 6 and 7 unused
    endcase
  endfunction

  // round the half-lsb sample to nearest, saturate, flip msb into twos complement
  function automatic logic [15:0] to_tc(input logic [16:0] smp);
    logic [16:0] sum;
    sum = {1'b0, smp[16:1]} + {16'h0000, smp[0]};
    if (sum[16]) begin
      to_tc = 16'h7fff;
    end else begin
      to_tc = {~sum[15], sum[14:0]};
    end
  endfunction

  // pin synchroniser: two flip-flops ahead of any logic
  localparam logic [7:0] SYNC_RESET = 8'h80; // reset pin idles high
  logic [7:0] pins_raw;
  logic [7:0] sync1_reg;     // first stage, read only by the second stage
  logic [7:0] sync2_reg;     // second stage
  assign pins_raw = {reset_pin_n_in, conversion_start_input_in, byte_serial_strap_in,
                     interface_select_strap_in, sequencer_strap_in,
                     hardware_range_strap_in, reference_source_strap_in};
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sync1_reg <= SYNC_RESET;
      sync2_reg <= SYNC_RESET;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  wire              pin_low  = ~sync2_reg[7];            // reset pin held low
  wire              conv_pin = sync2_reg[6];             // synchronised start pin
  wire rsl_pkg::rsl_straps_t strap_now = rsl_pkg::rsl_straps_t'(sync2_reg[5:0]);

  // reset pin tracker: counts low cycles, classifies at release
  rsl_pkg::rsl_rst_state_t rs_reg;
  rsl_pkg::rsl_rst_state_t rs_next;
  logic [rsl_pkg::CNT_W-1:0] low_cnt_reg;
  logic [rsl_pkg::CNT_W-1:0] low_cnt_next;
  localparam logic [rsl_pkg::CNT_W-1:0] FULL_CNT = rsl_pkg::CNT_W'(rsl_pkg::FULL_MIN_CYC);
  localparam logic [rsl_pkg::CNT_W-1:0] PART_CNT = rsl_pkg::CNT_W'(rsl_pkg::PARTIAL_MIN_CYC);
  wire release_seen = (rs_reg == rsl_pkg::RSL_RS_LOW) && !pin_low;
  // a release is classified by how long the pin stayed low
  wire full_rel     = release_seen && (low_cnt_reg >= FULL_CNT);
  wire part_rel     = release_seen && (low_cnt_reg >= PART_CNT) && !full_rel;

  // next state: any low level enters tracking, whatever else is running
  always_comb begin
    rs_next      = rs_reg;
    low_cnt_next = low_cnt_reg;
    unique case (rs_reg)
      rsl_pkg::RSL_RS_RUN: begin
        if (pin_low) begin
          rs_next      = rsl_pkg::RSL_RS_LOW;
          low_cnt_next = rsl_pkg::CNT_W'(1);
        end
      end
      rsl_pkg::RSL_RS_LOW: begin
        if (!pin_low) begin
          rs_next = rsl_pkg::RSL_RS_RUN;
        end else if (low_cnt_reg < FULL_CNT) begin
          low_cnt_next = low_cnt_reg + rsl_pkg::CNT_W'(1); // saturates at full
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rs_reg      <= rsl_pkg::RSL_RS_RUN;
      low_cnt_reg <= '0;
    end else begin
      rs_reg      <= rs_next;
      low_cnt_reg <= low_cnt_next;
    end
  end

  // straps: caught only at a full release; partial releases leave them
  rsl_pkg::rsl_straps_t straps_reg;
  logic                 last_full_reg;  // last classified reset was full
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      straps_reg    <= rsl_pkg::STRAPS_RESET;
      last_full_reg <= 1'b0;
    end else begin
      if (full_rel) begin
        straps_reg <= strap_now;
      end
      if (full_rel || part_rel) begin
        last_full_reg <= full_rel;
      end
    end
  end

  // decoded modes from latched straps
  wire soft_mode = (straps_reg.hw_range == rsl_pkg::HW_SOFTWARE);
  wire rsl_pkg::rsl_iface_t iface =
    !straps_reg.iface_sel   ? rsl_pkg::RSL_IF_PARALLEL :
    straps_reg.byte_serial  ? rsl_pkg::RSL_IF_BYTE :
                              rsl_pkg::RSL_IF_SERIAL;
  // hardware range map; strap 00 never reaches here
  wire [2:0] hw_range =
    (straps_reg.hw_range == 2'h1) ? rsl_pkg::RNG_2P5 :
    (straps_reg.hw_range == 2'h2) ? rsl_pkg::RNG_5 : rsl_pkg::RNG_10;

  // avalon slave: one wait cycle, then answer with registered read data
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0]  cfg_reg;     // software settings
  logic        early_reg;   // sticky: start came too soon after release
  wire req      = avs_read_in || avs_write_in;
  wire wr_done  = avs_write_in && ack_reg;
  wire wr_cfg   = wr_done && (avs_address_in == rsl_pkg::ADDR_CONFIG) && avs_byteenable_in[0];
  wire wr_stat  = wr_done && (avs_address_in == rsl_pkg::ADDR_STATUS) && avs_byteenable_in[1];
  wire early_clr = wr_stat && avs_writedata_in[rsl_pkg::ST_EARLY_BIT];
  assign avs_waitrequest_out = req && !ack_reg;
  assign avs_readdata_out    = rdata_reg;

  // effective range and sequencer enable
  wire [2:0] range_sel = soft_mode ? cfg_reg[rsl_pkg::CFG_RANGE_LSB +: 3] : hw_range;
  wire seq_en = soft_mode ? cfg_reg[rsl_pkg::CFG_SEQ_EN_BIT] : straps_reg.seq;
  wire burst  = cfg_reg[rsl_pkg::CFG_BURST_BIT];
  wire [2:0] seq_last = cfg_reg[rsl_pkg::CFG_LAST_LSB +: 3];

  // conversion engine state
  logic        busy_reg;
  logic        valid_reg;
  logic [rsl_pkg::CNT_W-1:0] conv_cnt_reg;
  logic [rsl_pkg::CNT_W-1:0] settle_cnt_reg;
  logic        conv_prev_reg;
  logic [2:0]  chan_reg;
  logic [15:0] res_a_reg;
  logic [15:0] res_b_reg;
  logic        read_res_reg;   // a result read is in flight
  wire conv_rise  = conv_pin && !conv_prev_reg;
  wire conv_start = conv_rise && !pin_low && !busy_reg;
  wire conv_done  = busy_reg && !pin_low && (conv_cnt_reg == rsl_pkg::CNT_W'(1));
  wire at_last    = (chan_reg == seq_last);
  // burst keeps converting down the sequence from a single start
  wire burst_more = conv_done && seq_en && burst && !at_last;
  wire [2:0] chan_step = at_last ? 3'h0 : chan_reg + 3'h1;
  wire rd_result  = avs_read_in && ((avs_address_in == rsl_pkg::ADDR_RESULT_A) ||
                                    (avs_address_in == rsl_pkg::ADDR_RESULT_B));

  // read mux, built before the answer cycle
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  always_comb begin
    status_word = 32'h00000000;
    status_word[rsl_pkg::ST_BANDGAP_BIT]    = straps_reg.ref_src;
    status_word[rsl_pkg::ST_SOFT_BIT]       = soft_mode;
    status_word[rsl_pkg::ST_SEQ_BIT]        = seq_en;
    status_word[rsl_pkg::ST_IFACE_LSB +: 2] = iface;
    status_word[rsl_pkg::ST_HWRNG_LSB +: 2] = straps_reg.hw_range;
    status_word[rsl_pkg::ST_BUSY_BIT]       = busy_reg;
    status_word[rsl_pkg::ST_VALID_BIT]      = valid_reg;
    status_word[rsl_pkg::ST_FULL_BIT]       = last_full_reg;
    status_word[rsl_pkg::ST_EARLY_BIT]      = early_reg;
    status_word[rsl_pkg::ST_CHAN_LSB +: 3]  = chan_reg;
    status_word[rsl_pkg::ST_BYTESER_BIT]    = straps_reg.byte_serial;
    unique case (avs_address_in)
      rsl_pkg::ADDR_STATUS:   rd_mux = status_word;
      rsl_pkg::ADDR_CONFIG:   rd_mux = {24'h000000, cfg_reg};
      rsl_pkg::ADDR_RESULT_A: rd_mux = {16'h0000, res_a_reg};
      rsl_pkg::ADDR_RESULT_B: rd_mux = {16'h0000, res_b_reg};
      rsl_pkg::ADDR_LSB:      rd_mux = {23'h000000, lsb_of(range_sel)};
      default:                rd_mux = 32'h00000000; // unmapped reads as zero
    endcase
  end

  // bus handshake: ack pulses once per request
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ack_reg   <= req && !ack_reg;
      rdata_reg <= (avs_read_in && !ack_reg) ? rd_mux : rdata_reg;
    end
  end

  // settings: full release restores defaults, partial leaves them
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_reg <= rsl_pkg::CFG_RESET;
    end else if (full_rel) begin
      cfg_reg <= rsl_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= avs_writedata_in[7:0];
    end
  end

  // early start flag: a set in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      early_reg <= 1'b0;
    end else if (conv_rise && settle_cnt_reg != '0) begin
      early_reg <= 1'b1;                            // host broke the gap
    end else if (early_clr) begin
      early_reg <= 1'b0;
    end
  end

  // settle counter after a full or partial release; a start inside it may be corrupted
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      settle_cnt_reg <= '0;
    end else if (full_rel || part_rel) begin
      settle_cnt_reg <= rsl_pkg::CNT_W'(rsl_pkg::RESET_TO_CONV_CYC);
    end else if (settle_cnt_reg != '0) begin
      settle_cnt_reg <= settle_cnt_reg - rsl_pkg::CNT_W'(1);
    end
  end

  // conversion control: starts, burst chaining and channel stepping
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_reg      <= 1'b0;
      conv_cnt_reg  <= '0;
      conv_prev_reg <= 1'b0;
      chan_reg      <= 3'h0;
    end else begin
      conv_prev_reg <= conv_pin;
      if (pin_low) begin
        busy_reg <= 1'b0;                           // abort at once
        if (full_rel || part_rel || !busy_reg) begin
          chan_reg <= chan_reg;
        end
      end else if (full_rel || part_rel) begin
        chan_reg <= 3'h0;                           // modules reinitialised
      end else if (conv_start || burst_more) begin
        busy_reg     <= 1'b1;
        conv_cnt_reg <= rsl_pkg::CNT_W'(rsl_pkg::CONV_CYC);
        if (burst_more) begin
          chan_reg <= chan_step;
        end
      end else if (conv_done) begin
        busy_reg <= 1'b0;
        if (seq_en) begin
          chan_reg <= chan_step;                    // one step per start
        end
      end else if (busy_reg) begin
        conv_cnt_reg <= conv_cnt_reg - rsl_pkg::CNT_W'(1);
      end
    end
  end

  // results: twos complement with half-lsb rounding, cleared by reset during read
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      res_a_reg    <= 16'h0000;
      res_b_reg    <= 16'h0000;
      valid_reg    <= 1'b0;
      read_res_reg <= 1'b0;
    end else begin
      read_res_reg <= rd_result && !ack_reg;
      if (pin_low) begin
        valid_reg <= 1'b0;                          // aborted data is invalid
        if (rd_result || read_res_reg) begin
          res_a_reg <= 16'h0000;
          res_b_reg <= 16'h0000;
        end
      end else if (conv_done) begin
        res_a_reg <= to_tc(core_sample_a_in);
        res_b_reg <= to_tc(core_sample_b_in);
        valid_reg <= 1'b1;
      end
    end
  end

  // outputs
  assign bandgap_enable_out      = straps_reg.ref_src;
  assign reference_io_pin_oe_out = straps_reg.ref_src;            // external in when low
  assign ref_buffer_enable_out   = 1'b1;
  assign software_mode_out       = soft_mode;
  // data pins take writes only in software parallel or byte modes
  assign data_pins_write_en_out  = soft_mode && (iface != rsl_pkg::RSL_IF_SERIAL);
  assign iface_mode_out          = iface;
  assign range_code_out          = range_sel;
  assign lsb_uv_out              = lsb_of(range_sel);
  assign sequencer_enable_out    = seq_en;
  assign channel_out             = chan_reg;
  assign conv_busy_out           = busy_reg;
  assign result_valid_out        = valid_reg;
  assign device_in_reset_out     = pin_low;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  buffer_on_a: assert property (ref_buffer_enable_out && (bandgap_enable_out == reference_io_pin_oe_out))
    else $error("reference buffer or pin drive wrong");
  bandgap_sel_a: assert property (full_rel |=> bandgap_enable_out == $past(strap_now.ref_src))
    else $error("band-gap does not follow latched strap");
  strap_hold_a: assert property (!full_rel |=> $stable(straps_reg))
    else $error("straps changed outside a full release");
  full_class_a: assert property (release_seen && low_cnt_reg >= FULL_CNT |=> last_full_reg)
    else $error("long reset not classified full");
  partial_keep_a: assert property (part_rel && !wr_cfg |=> $stable(cfg_reg))
    else $error("partial reset disturbed settings");
  full_default_a: assert property (full_rel |=> cfg_reg == rsl_pkg::CFG_RESET)
    else $error("full reset left settings");
  abort_conv_a: assert property (pin_low |=> !busy_reg && !valid_reg)
    else $error("conversion survived reset");
  read_clear_a: assert property (pin_low && rd_result |=> res_a_reg == 16'h0000 && res_b_reg == 16'h0000)
    else $error("results not cleared by reset during read");
  seq_strap_a: assert property (full_rel && strap_now.seq && strap_now.hw_range != 2'h0 |=> sequencer_enable_out)
    else $error("sequencer strap ignored");
  tc_format_a: assert property (conv_done |=> res_a_reg == to_tc($past(core_sample_a_in)))
    else $error("result not rounded twos complement");
  iface_par_a: assert property (!straps_reg.iface_sel |-> iface_mode_out == rsl_pkg::RSL_IF_PARALLEL)
    else $error("parallel interface not selected");
  bus_answer_a: assert property (req && !ack_reg |=> !avs_waitrequest_out || !req)
    else $error("bus answer late");

  full_rel_c:  cover property (full_rel);
  part_rel_c:  cover property (part_rel ##[1:200] conv_done);
  burst_c:     cover property (burst_more ##1 busy_reg);
  early_c:     cover property (early_reg && early_clr);

endmodule

`default_nettype wire

// ### tb/rsl_host.sv
// host model: drives the device reset pin
// assumes the bench calls pulse with a low time in cycles
`timescale 1ns/1ns
`default_nettype none
module rsl_host (
  input  wire logic clk_in,   // bench clock
  output logic      rst_n_out // reset pin, active low
);
  initial rst_n_out = 1'b1;
  // low for n cycles, then no start until the device has settled
  task automatic pulse(input int n);
    rst_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    rst_n_out <= 1'b1;
    repeat (25) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the reset and strap latch
// assumes the host model on the reset pin and a 50 mhz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic sys_clk_in = 0, rst_in = 1, cs = 0, rd = 0, wr = 0, rf = 0, sq = 0, ifs = 0, bs = 0;
  logic [1:0]  hw = 0;
  logic [16:0] sa = 0, sb = 0;
  logic [4:0]  ad = 0;
  logic [31:0] wd = 0, q, st, seed = 32'h2755c521;
  wire logic [31:0] rdat;
  wire logic wreq, pin_n, bg, rb, vld, oe, sw, dw, se, bz, ir;
  wire logic [1:0] im;
  wire logic [2:0] rc, ch;
  wire logic [8:0] lsb;
  int failures = 0, checked = 0, lt[4] = '{305, 76, 152, 305}, rt[4] = '{4, 0, 2, 4};
  always #10 sys_clk_in = ~sys_clk_in;
  rsl_host host (.clk_in(sys_clk_in), .rst_n_out(pin_n));
  rsl_reset_strap dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reset_pin_n_in(pin_n),
    .conversion_start_input_in(cs), .reference_source_strap_in(rf), .sequencer_strap_in(sq),
    .hardware_range_strap_in(hw), .interface_select_strap_in(ifs), .byte_serial_strap_in(bs),
    .core_sample_a_in(sa), .core_sample_b_in(sb), .avs_address_in(ad), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .bandgap_enable_out(bg), .reference_io_pin_oe_out(oe),
    .ref_buffer_enable_out(rb), .software_mode_out(sw), .data_pins_write_en_out(dw),
    .iface_mode_out(im), .range_code_out(rc), .lsb_uv_out(lsb), .sequencer_enable_out(se),
    .channel_out(ch), .conv_busy_out(bz), .result_valid_out(vld), .device_in_reset_out(ir));
  // xorshift source of random straps and samples
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // expected result: round half up, saturate, offset to twos complement
  function automatic logic [31:0] cv(input logic [16:0] u);
    int e;
    e = (int'(u) + 1) >> 1;
    if (e > 65535) e = 65535;
    return 32'(e) ^ 32'h8000;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one bus cycle; held until waitrequest is low, data taken at that edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    ad <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    // waitrequest and read data are taken as they stand at the rising edge
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50) begin
      failures++;
      test_done();
    end
  endtask
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // every range strap code with random other straps, full then partial reset
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      {bs, ifs, sq, rf} <= seed[3:0];
      hw <= k[1:0];
      host.pulse(70);
      {bs, ifs, sq, rf, hw} <= ~{seed[3:0], k[1:0]};
      st = 32'h200 | seed[3] << 14 | k << 5 | (seed[2] ? (seed[3] ? 2 : 1) : 0) << 3;
      st = st | (seed[1] && k != 0) << 2 | (k == 0) << 1 | seed[0];
      acc(0, rsl_pkg::ADDR_STATUS, 0);
      chk(q & 32'h667f, st);
      chk(bg, seed[0]);
      chk(rb, 1);
      chk(lsb, lt[k]);
      chk({oe, sw, dw, se, im, rc},
          {seed[0], k == 0, k == 0 && st[4:3] != 1, st[2], st[4:3], 3'(rt[k])});
      host.pulse(10);
      acc(0, rsl_pkg::ADDR_STATUS, 0);
      chk(q & 32'h667f, st & ~32'h200);
    end
    // conversions with random samples, then one aborted by reset
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      sa <= seed[16:0];
      sb <= seed[31:15];
      cs <= 1'b1;
      repeat (30) @(posedge sys_clk_in);
      cs <= 1'b0;
      chk(vld, 1);
      acc(0, rsl_pkg::ADDR_RESULT_A, 0);
      chk(q, cv(sa));
      acc(0, rsl_pkg::ADDR_RESULT_B, 0);
      chk(q, cv(sb));
    end
    // reset during a result read clears both result registers
    fork
      host.pulse(10);
      begin
        repeat (2) @(posedge sys_clk_in);
        acc(0, rsl_pkg::ADDR_RESULT_A, 0);
      end
    join
    acc(0, rsl_pkg::ADDR_RESULT_A, 0);
    chk(q, 0);
    acc(0, rsl_pkg::ADDR_RESULT_B, 0);
    chk(q, 0);
    cs <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    chk(bz, 1);
    cs <= 1'b0;
    fork
      host.pulse(10);
      begin
        repeat (4) @(posedge sys_clk_in);
        chk(ir, 1);
      end
    join
    chk({vld, bz}, 0);
    // a start inside the settle gap after release sets the sticky flag
    fork
      host.pulse(10);
      begin
        repeat (16) @(posedge sys_clk_in);
        cs <= 1'b1;
      end
    join
    cs <= 1'b0;
    acc(0, rsl_pkg::ADDR_STATUS, 0);
    chk(q[10], 1);
    acc(1, rsl_pkg::ADDR_STATUS, 32'h400);
    acc(0, rsl_pkg::ADDR_STATUS, 0);
    chk(q[10], 0);
    // software mode: range from the config register, unmapped read
    hw <= 2'h0;
    host.pulse(70);
    acc(1, rsl_pkg::ADDR_CONFIG, 32'h75);
    @(posedge sys_clk_in);
    chk(lsb, 366);
    acc(0, rsl_pkg::ADDR_LSB, 0);
    chk(q, 366);
    acc(0, 5'h14, 0);
    chk(q, 0);
    // sequencer: one step per start, then a burst down to the last channel
    acc(1, rsl_pkg::ADDR_CONFIG, 32'ha5);
    for (int j = 0; j < 2; j++) begin
      cs <= 1'b1;
      repeat (30) @(posedge sys_clk_in);
      cs <= 1'b0;
      acc(0, rsl_pkg::ADDR_STATUS, 0);
      chk(q & 32'h3880, j ? 32'h1080 : 32'h0800);
      acc(1, rsl_pkg::ADDR_CONFIG, 32'had);
    end
    repeat (30) @(posedge sys_clk_in);
    chk({bz, ch}, 0);
    test_done();
  end
endmodule
`default_nettype wire
